// *** interval_timer_pkg.sv ***
// Constants and types shared by the four-channel interval timer block
package interval_timer_pkg;

  // ---------------------------------------------------------------
  // Port map of the byte-wide host I/O window
  // ---------------------------------------------------------------
  localparam logic [7:0] TIMER0_COUNT_PORT = 8'h40;
  localparam logic [7:0] TIMER1_COUNT_PORT = 8'h41;
  localparam logic [7:0] TIMER2_COUNT_PORT = 8'h42;
  localparam logic [7:0] TIMERS_0_TO_2_SETUP_WORD = 8'h43;
  localparam logic [7:0] TIMER3_COUNT_PORT = 8'h44;
  localparam logic [7:0] RESERVED_PORT_A = 8'h45;
  localparam logic [7:0] RESERVED_PORT_B = 8'h46;
  localparam logic [7:0] TIMER3_SETUP_WORD = 8'h47;
  localparam logic [7:0] COUNT_PORT [0:3] = '{8'h40, 8'h41, 8'h42, 8'h44};
  localparam logic [7:0] IDLE_READ = 8'h00;

  // ---------------------------------------------------------------
  // Setup word fields
  // ---------------------------------------------------------------
  localparam int SW_SEL_HI = 7;
  localparam int SW_SEL_LO = 6;
  localparam int SW_FMT_HI = 5;
  localparam int SW_FMT_LO = 4;
  localparam int SW_MODE_HI = 3;
  localparam int SW_MODE_LO = 1;
  localparam int SW_BCD_BIT = 0;
  localparam int RB_NO_COUNT_BIT = 5;
  localparam int RB_NO_STATUS_BIT = 4;
  localparam logic [1:0] SEL_READBACK = 2'h3;

  // Byte format of count reads and writes
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LSB = 2'h1;
  localparam logic [1:0] FMT_MSB = 2'h2;
  localparam logic [1:0] FMT_BOTH = 2'h3;

  // ---------------------------------------------------------------
  // Counting constants
  // ---------------------------------------------------------------
  localparam int TIMER_COUNT = 4;
  localparam int DIGITS = 4;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_TWO = 16'h0002;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_INT = 3'h0,
    MODE_ONESHOT = 3'h1,
    MODE_RATE = 3'h2,
    MODE_SQUARE = 3'h3,
    MODE_SW_STROBE = 3'h4,
    MODE_HW_STROBE = 3'h5
  } timer_mode_t;

endpackage : interval_timer_pkg

// *** interval_timer_gate_and_programming.sv ***
// Four 16-bit interval timers with gate handling and byte-wide programming ports

// How it works
// - Gate is sampled on each rising edge of the shared timer clock.
// - Modes 0, 2, 3, 4: sampled low gate stops counting, high allows it.
// - Modes 1, 2, 3, 5: gate rising edge sets a trigger flop, cleared once sampled.
// - Modes 2 and 3: gate edge restarts the count, low gate suspends it.
// - Mode 5: each trigger reloads the initial count on next timer clock.
// - Mode 5: new count waits for next trigger; running sequence continues.
// - Loads and decrements happen on the falling edge of the timer clock.
// - Initial count zero means 65536 binary or 10000 decimal.
// - Modes 0, 1, 4, 5 wrap past zero to FFFF or 9999 and continue.
// - Modes 2 and 3 reload the stored count each period.
// - Ports 40h-42h, 44h are counters, 43h and 47h setup words, 45h-46h reserved.
// - Counts are written and read a byte at a time in the chosen format.
// - Setup word picks timer, mode, binary or decimal, byte format, or a command.
// - State after reset is not guaranteed; software programs every timer. Here reset loads mode 0, LSB format and output high.
// - A new count never changes the programmed mode and follows its format.
// - Setup word resets the timer at once and puts its output at its start level.
// - Counts read directly, through a latch command, or through read-back.
// - Modes 2 and 3: gate falling while output low raises output at once.
// - Mode 1: output low from the clock after a trigger until count hits zero.
// - Gates of timers 0 and 1 are held high inside.
module interval_timer_gate_and_programming (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host I/O port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Timer pins
  input wire logic shared_timer_clock_input,
  input wire logic [1:0] ext_gate,
  output logic [3:0] timer_output_pin
);

  // Local copies of package constants, declared ahead of every use
  localparam logic [15:0] COUNT_ONE_W = interval_timer_pkg::COUNT_ONE;
  localparam logic [15:0] COUNT_TWO_W = interval_timer_pkg::COUNT_TWO;
  localparam logic [15:0] COUNT_RESET_W = interval_timer_pkg::COUNT_RESET;
  localparam int SW_SEL_HI = interval_timer_pkg::SW_SEL_HI;
  localparam int SW_SEL_LO = interval_timer_pkg::SW_SEL_LO;
  localparam int SW_FMT_HI = interval_timer_pkg::SW_FMT_HI;
  localparam int SW_FMT_LO = interval_timer_pkg::SW_FMT_LO;
  localparam int SW_MODE_HI = interval_timer_pkg::SW_MODE_HI;
  localparam int SW_MODE_LO = interval_timer_pkg::SW_MODE_LO;
  localparam int SW_BCD_BIT = interval_timer_pkg::SW_BCD_BIT;
  localparam int RB_NO_COUNT_BIT = interval_timer_pkg::RB_NO_COUNT_BIT;
  localparam int RB_NO_STATUS_BIT = interval_timer_pkg::RB_NO_STATUS_BIT;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Down-count by one, binary or four decimal digits
  function automatic logic [15:0] dec_one(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - COUNT_ONE_W;
    end else begin
      for (int d = 0; d < interval_timer_pkg::DIGITS; d++) begin
        if (borrow) begin
          if (r[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = interval_timer_pkg::BCD_NINE;
          end else begin
            r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : dec_one

  // ---------------------------------------------------------------
  // Pin synchronisers and timer clock edge detection
  // ---------------------------------------------------------------
  logic tclk_meta_ff, tclk_sync_ff, tclk_prev_ff;
  logic [1:0] gate_meta_ff, gate_sync_ff;
  logic tick_rise, tick_fall;
  logic [3:0] gate_all;

  // Two flops on every pin; the second feeds logic, as does a third edge flop on the timer clock
  always_ff @(posedge clk) begin
    if (rst) begin
      tclk_meta_ff <= 1'b0;
      tclk_sync_ff <= 1'b0;
      tclk_prev_ff <= 1'b0;
      gate_meta_ff <= 2'h0;
      gate_sync_ff <= 2'h0;
    end else begin
      tclk_meta_ff <= shared_timer_clock_input;
      tclk_sync_ff <= tclk_meta_ff;
      tclk_prev_ff <= tclk_sync_ff;
      gate_meta_ff <= ext_gate;
      gate_sync_ff <= gate_meta_ff;
    end
  end

  // Timer clock edges become one-cycle enables
  assign tick_rise = tclk_sync_ff & ~tclk_prev_ff;
  assign tick_fall = ~tclk_sync_ff & tclk_prev_ff;
  assign gate_all = {gate_sync_ff, 2'b11};

  // ---------------------------------------------------------------
  // Host port decode
  // ---------------------------------------------------------------
  logic wr_sw1, wr_sw2;
  logic [7:0] rd_byte [0:3];
  logic [7:0] rdata_ff, nxt_rdata;

  // Reserved ports match nothing below, so they are inert
  assign wr_sw1 = io_wr && (io_addr == interval_timer_pkg::TIMERS_0_TO_2_SETUP_WORD);
  assign wr_sw2 = io_wr && (io_addr == interval_timer_pkg::TIMER3_SETUP_WORD);

  // Read data is registered; unmapped and reserved ports return zero
  always_comb begin
    nxt_rdata = interval_timer_pkg::IDLE_READ;
    for (int t = 0; t < interval_timer_pkg::TIMER_COUNT; t++) begin
      if (io_rd && io_addr == interval_timer_pkg::COUNT_PORT[t]) begin
        nxt_rdata = rd_byte[t];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= interval_timer_pkg::IDLE_READ;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign io_rdata = rdata_ff;

  // ---------------------------------------------------------------
  // Per-timer logic
  // ---------------------------------------------------------------
  for (genvar i = 0; i < interval_timer_pkg::TIMER_COUNT; i++) begin : g_timer
    localparam logic [1:0] SEL_CODE = (i < 3) ? 2'(i) : 2'h0;
    localparam int RB_BIT = (i < 3) ? i + 1 : 1;

    interval_timer_pkg::timer_mode_t mode_ff, nxt_mode;
    logic [1:0] fmt_ff, nxt_fmt;
    logic [15:0] cr_ff, nxt_cr, ce_ff, nxt_ce, ol_ff, nxt_ol;
    logic [7:0] stat_ff, nxt_stat;
    logic bcd_ff, nxt_bcd, out_ff, nxt_out, run_ff, nxt_run;
    logic cr_ok_ff, nxt_cr_ok, newcnt_ff, nxt_newcnt, null_ff, nxt_null;
    logic wr_hi_ff, nxt_wr_hi, rd_hi_ff, nxt_rd_hi, hold_ff, nxt_hold;
    logic cnt_lat_ff, nxt_cnt_lat, stat_lat_ff, nxt_stat_lat;
    logic gate_lvl_ff, nxt_gate_lvl, gate_prev_ff, trig_ff, nxt_trig;
    logic trig_smp_ff, nxt_trig_smp;
    logic sw_wr, sw_this, latch_this, rb_this, cnt_wr, cnt_rd, gate_rise, trig_go;
    logic [2:0] mode_in;
    logic [15:0] even_cr, live;

    // Decode of accesses aimed at this timer
    assign sw_wr = (i < 3) ? wr_sw1 : wr_sw2;
    assign sw_this = sw_wr && io_wdata[SW_SEL_HI:SW_SEL_LO] == SEL_CODE
                     && io_wdata[SW_FMT_HI:SW_FMT_LO] != interval_timer_pkg::FMT_LATCH;
    assign latch_this = sw_wr && io_wdata[SW_SEL_HI:SW_SEL_LO] == SEL_CODE
                        && io_wdata[SW_FMT_HI:SW_FMT_LO] == interval_timer_pkg::FMT_LATCH;
    assign rb_this = sw_wr && io_wdata[SW_SEL_HI:SW_SEL_LO] == interval_timer_pkg::SEL_READBACK
                     && io_wdata[RB_BIT];
    assign cnt_wr = io_wr && io_addr == interval_timer_pkg::COUNT_PORT[i];
    assign cnt_rd = io_rd && io_addr == interval_timer_pkg::COUNT_PORT[i];
    assign gate_rise = gate_all[i] & ~gate_prev_ff;
    assign trig_go = trig_smp_ff && mode_ff != interval_timer_pkg::MODE_INT
                     && mode_ff != interval_timer_pkg::MODE_SW_STROBE;
    // Modes 6 and 7 alias onto 2 and 3
    assign mode_in = (io_wdata[SW_MODE_HI:SW_MODE_LO] > 3'h5)
                     ? {1'b0, io_wdata[SW_MODE_LO+1:SW_MODE_LO]} : io_wdata[SW_MODE_HI:SW_MODE_LO];
    assign even_cr = {cr_ff[15:1], 1'b0};
    assign live = cnt_lat_ff ? ol_ff : ce_ff;
    assign rd_byte[i] = stat_lat_ff ? stat_ff : (rd_hi_ff ? live[15:8] : live[7:0]);
    assign timer_output_pin[i] = out_ff;

    // Next state: timer clock edges first, then host writes, setup word last
    always_comb begin
      nxt_mode = mode_ff; nxt_fmt = fmt_ff; nxt_bcd = bcd_ff; nxt_cr = cr_ff;
      nxt_ce = ce_ff; nxt_ol = ol_ff; nxt_stat = stat_ff; nxt_out = out_ff;
      nxt_run = run_ff; nxt_cr_ok = cr_ok_ff; nxt_newcnt = newcnt_ff; nxt_null = null_ff;
      nxt_wr_hi = wr_hi_ff; nxt_rd_hi = rd_hi_ff; nxt_hold = hold_ff;
      nxt_cnt_lat = cnt_lat_ff; nxt_stat_lat = stat_lat_ff;
      nxt_gate_lvl = gate_lvl_ff; nxt_trig_smp = trig_smp_ff;
      // Short trigger pulses are held until the timer clock samples them
      nxt_trig = trig_ff | gate_rise;
      if (tick_rise) begin
        nxt_gate_lvl = gate_all[i];
        nxt_trig_smp = trig_ff;
        nxt_trig = gate_rise;
      end
      if (tick_fall) begin
        nxt_trig_smp = 1'b0;
        case (mode_ff)
          interval_timer_pkg::MODE_INT: begin
            if (newcnt_ff) begin
              nxt_ce = cr_ff; nxt_newcnt = 1'b0; nxt_null = 1'b0; nxt_run = 1'b1;
            end else if (run_ff && gate_lvl_ff) begin
              nxt_ce = dec_one(ce_ff, bcd_ff);
              if (ce_ff == COUNT_ONE_W) nxt_out = 1'b1;
            end
          end
          interval_timer_pkg::MODE_ONESHOT: begin
            if (trig_go && cr_ok_ff) begin
              nxt_ce = cr_ff; nxt_null = 1'b0; nxt_out = 1'b0; nxt_run = 1'b1;
            end else if (run_ff) begin
              nxt_ce = dec_one(ce_ff, bcd_ff);
              if (ce_ff == COUNT_ONE_W) nxt_out = 1'b1;
            end
          end
          interval_timer_pkg::MODE_RATE: begin
            if (cr_ok_ff && (trig_go || (newcnt_ff && !run_ff))) begin
              nxt_ce = cr_ff; nxt_out = 1'b1; nxt_run = 1'b1;
              nxt_newcnt = 1'b0; nxt_null = 1'b0;
            end else if (run_ff && gate_lvl_ff) begin
              if (!out_ff) begin
                nxt_ce = cr_ff; nxt_out = 1'b1;
                nxt_newcnt = 1'b0; nxt_null = 1'b0;
              end else begin
                nxt_ce = dec_one(ce_ff, bcd_ff);
                if (ce_ff == COUNT_TWO_W) nxt_out = 1'b0;
              end
            end
          end
          interval_timer_pkg::MODE_SQUARE: begin
            // Odd counts spend one extra clock high, held by hold_ff
            if (cr_ok_ff && (trig_go || (newcnt_ff && !run_ff))) begin
              nxt_ce = even_cr; nxt_out = 1'b1; nxt_run = 1'b1; nxt_hold = cr_ff[0];
              nxt_newcnt = 1'b0; nxt_null = 1'b0;
            end else if (run_ff && gate_lvl_ff) begin
              if (hold_ff) begin
                nxt_hold = 1'b0;
              end else if (ce_ff == COUNT_TWO_W) begin
                nxt_ce = even_cr; nxt_out = ~out_ff;
                nxt_hold = cr_ff[0] & ~out_ff;
                nxt_newcnt = 1'b0; nxt_null = 1'b0;
              end else begin
                nxt_ce = dec_one(dec_one(ce_ff, bcd_ff), bcd_ff);
              end
            end
          end
          interval_timer_pkg::MODE_SW_STROBE: begin
            nxt_out = 1'b1;
            if (newcnt_ff) begin
              nxt_ce = cr_ff; nxt_newcnt = 1'b0; nxt_null = 1'b0; nxt_run = 1'b1;
            end else if (cr_ok_ff && gate_lvl_ff) begin
              nxt_ce = dec_one(ce_ff, bcd_ff);
              if (run_ff && ce_ff == COUNT_ONE_W) begin
                nxt_out = 1'b0; nxt_run = 1'b0;
              end
            end
          end
          interval_timer_pkg::MODE_HW_STROBE: begin
            nxt_out = 1'b1;
            if (trig_go && cr_ok_ff) begin
              nxt_ce = cr_ff; nxt_null = 1'b0; nxt_run = 1'b1;
            end else if (!null_ff || run_ff) begin
              nxt_ce = dec_one(ce_ff, bcd_ff);
              if (run_ff && ce_ff == COUNT_ONE_W) begin
                nxt_out = 1'b0; nxt_run = 1'b0;
              end
            end
          end
          default: begin
            nxt_out = 1'b1;
          end
        endcase
      end
      // Modes 2 and 3: gate going low forces the output high without a timer clock
      if ((mode_ff == interval_timer_pkg::MODE_RATE || mode_ff == interval_timer_pkg::MODE_SQUARE)
          && !gate_all[i]) begin
        nxt_out = 1'b1;
      end
      // Count byte written in the programmed format; mode is left alone
      if (cnt_wr) begin
        if (fmt_ff == interval_timer_pkg::FMT_LSB) begin
          nxt_cr = {8'h00, io_wdata};
        end else if (fmt_ff == interval_timer_pkg::FMT_MSB) begin
          nxt_cr = {io_wdata, 8'h00};
        end else if (!wr_hi_ff) begin
          nxt_cr = {cr_ff[15:8], io_wdata};
        end else begin
          nxt_cr = {io_wdata, cr_ff[7:0]};
        end
        nxt_wr_hi = (fmt_ff == interval_timer_pkg::FMT_BOTH) ? ~wr_hi_ff : wr_hi_ff;
        if (fmt_ff != interval_timer_pkg::FMT_BOTH || wr_hi_ff) begin
          nxt_cr_ok = 1'b1; nxt_newcnt = 1'b1; nxt_null = 1'b1;
          if (mode_ff == interval_timer_pkg::MODE_INT) nxt_out = 1'b0;
        end
      end
      // Reads consume status first, then the latched count bytes
      if (cnt_rd) begin
        if (stat_lat_ff) begin
          nxt_stat_lat = 1'b0;
        end else begin
          nxt_rd_hi = (fmt_ff == interval_timer_pkg::FMT_BOTH) ? ~rd_hi_ff : rd_hi_ff;
          if (fmt_ff != interval_timer_pkg::FMT_BOTH || rd_hi_ff) nxt_cnt_lat = 1'b0;
        end
      end
      // A second latch before the first is read is ignored
      if ((latch_this || (rb_this && !io_wdata[RB_NO_COUNT_BIT])) && !cnt_lat_ff) begin
        nxt_ol = ce_ff; nxt_cnt_lat = 1'b1;
      end
      if (rb_this && !io_wdata[RB_NO_STATUS_BIT] && !stat_lat_ff) begin
        nxt_stat = {out_ff, null_ff, fmt_ff, mode_ff, bcd_ff};
        nxt_stat_lat = 1'b1;
      end
      // Setup word: immediate reset of this timer's control state
      if (sw_this) begin
        nxt_mode = interval_timer_pkg::timer_mode_t'(mode_in);
        nxt_fmt = io_wdata[SW_FMT_HI:SW_FMT_LO];
        nxt_bcd = io_wdata[SW_BCD_BIT];
        nxt_out = (mode_in != 3'h0);
        nxt_run = 1'b0; nxt_cr_ok = 1'b0; nxt_newcnt = 1'b0; nxt_null = 1'b1;
        nxt_hold = 1'b0; nxt_trig = 1'b0; nxt_trig_smp = 1'b0;
        nxt_cnt_lat = 1'b0; nxt_stat_lat = 1'b0;
        nxt_wr_hi = (io_wdata[SW_FMT_HI:SW_FMT_LO] == interval_timer_pkg::FMT_MSB);
        nxt_rd_hi = (io_wdata[SW_FMT_HI:SW_FMT_LO] == interval_timer_pkg::FMT_MSB);
      end
    end

    // Register stage; reset gives a quiet, unprogrammed timer
    always_ff @(posedge clk) begin
      if (rst) begin
        mode_ff <= interval_timer_pkg::MODE_INT; fmt_ff <= interval_timer_pkg::FMT_LSB;
        bcd_ff <= 1'b0; cr_ff <= COUNT_RESET_W; ce_ff <= COUNT_RESET_W; ol_ff <= COUNT_RESET_W;
        stat_ff <= interval_timer_pkg::STATUS_RESET; out_ff <= 1'b1; run_ff <= 1'b0;
        cr_ok_ff <= 1'b0; newcnt_ff <= 1'b0; null_ff <= 1'b1; wr_hi_ff <= 1'b0;
        rd_hi_ff <= 1'b0; hold_ff <= 1'b0; cnt_lat_ff <= 1'b0; stat_lat_ff <= 1'b0;
        gate_lvl_ff <= 1'b0; gate_prev_ff <= 1'b0; trig_ff <= 1'b0; trig_smp_ff <= 1'b0;
      end else begin
        mode_ff <= nxt_mode; fmt_ff <= nxt_fmt; bcd_ff <= nxt_bcd; cr_ff <= nxt_cr;
        ce_ff <= nxt_ce; ol_ff <= nxt_ol; stat_ff <= nxt_stat; out_ff <= nxt_out;
        run_ff <= nxt_run; cr_ok_ff <= nxt_cr_ok; newcnt_ff <= nxt_newcnt;
        null_ff <= nxt_null; wr_hi_ff <= nxt_wr_hi; rd_hi_ff <= nxt_rd_hi;
        hold_ff <= nxt_hold; cnt_lat_ff <= nxt_cnt_lat; stat_lat_ff <= nxt_stat_lat;
        gate_lvl_ff <= nxt_gate_lvl; gate_prev_ff <= gate_all[i]; trig_ff <= nxt_trig;
        trig_smp_ff <= nxt_trig_smp;
      end
    end
  end

endmodule : interval_timer_gate_and_programming

// *** interval_timer_gate_and_programming_assertions.sv ***
// Port-level checks for the four-channel interval timer
module interval_timer_gate_and_programming_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Timer pins
  input wire logic shared_timer_clock_input,
  input wire logic [1:0] ext_gate,
  input wire logic [3:0] timer_output_pin
);
  logic tclk_ff, nxt_tclk, periodic_ff, nxt_periodic;
  logic [3:0] fall_age_ff, nxt_fall_age, wr_age_ff, nxt_wr_age;
  logic [5:0] gate_low_ff, nxt_gate_low;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Ages saturate so a long quiet spell never wraps back to small
  always_comb begin
    nxt_tclk = shared_timer_clock_input;
    nxt_fall_age = fall_age_ff + {3'h0, fall_age_ff != 4'hf};
    if (tclk_ff && !shared_timer_clock_input) nxt_fall_age = 4'h0;
    nxt_wr_age = io_wr ? 4'h0 : wr_age_ff + {3'h0, wr_age_ff != 4'hf};
    nxt_gate_low = ext_gate[0] ? 6'h00 : gate_low_ff + {5'h00, gate_low_ff != 6'h3f};
    nxt_periodic = periodic_ff;
    if (io_wr && io_addr == 8'h43 && io_wdata[7:6] == 2'h2 && io_wdata[5:4] != 2'h0) begin
      nxt_periodic = io_wdata[2];
    end
  end

  // Helper registers
  always_ff @(posedge clk) begin
    tclk_ff <= rst ? 1'b0 : nxt_tclk;
    fall_age_ff <= rst ? 4'hf : nxt_fall_age;
    wr_age_ff <= rst ? 4'hf : nxt_wr_age;
    gate_low_ff <= rst ? 6'h00 : nxt_gate_low;
    periodic_ff <= rst ? 1'b0 : nxt_periodic;
  end

  // A regular setup word for one timer
  sequence s_setup(logic [7:0] a);
    io_wr && io_addr == a && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != 2'h0;
  endsequence

  a_reset_outputs_idle: assert property (disable iff (1'b0)
    rst |=> timer_output_pin == 4'hf && io_rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_idle_read_zero: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_reserved_read_zero: assert property (io_rd
    && !(io_addr inside {8'h40, 8'h41, 8'h42, 8'h44}) |=> io_rdata == 8'h00)
    else $error("read of a non-counter port returned data");
  a_setup_out_high: assert property (s_setup(8'h43) ##0 io_wdata[3:1] != 3'h0
    |=> timer_output_pin[0]) else $error("timer 0 output not high after setup");
  a_setup_out_low: assert property (s_setup(8'h43) ##0 io_wdata[3:1] == 3'h0
    |=> !timer_output_pin[0]) else $error("timer 0 output not low after mode 0 setup");
  a_setup3_out_high: assert property (s_setup(8'h47) ##0 io_wdata[3:1] != 3'h0
    |=> timer_output_pin[3]) else $error("timer 3 output not high after setup");
  a_change_on_fall: assert property ($changed(timer_output_pin[1:0])
    |-> fall_age_ff <= 4'h8 || wr_age_ff <= 4'h3)
    else $error("ungated output moved away from a timer clock fall");
  a_gate_force_high: assert property ($fell(ext_gate[0]) && periodic_ff
    && !timer_output_pin[2] |-> ##[1:5] timer_output_pin[2])
    else $error("timer 2 output not forced high by gate fall");
  a_gate_low_hold: assert property (gate_low_ff >= 6'h1e && periodic_ff
    |-> !$fell(timer_output_pin[2])) else $error("timer 2 counted with gate low");
endmodule : interval_timer_gate_and_programming_assertions

bind interval_timer_gate_and_programming interval_timer_gate_and_programming_assertions
  i_interval_timer_gate_and_programming_assertions (.clk(clk), .rst(rst), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .shared_timer_clock_input(shared_timer_clock_input), .ext_gate(ext_gate),
  .timer_output_pin(timer_output_pin));

// *** timer_host_model.sv ***
// Host processor model driving the timer I/O ports
module timer_host_model (
  // Clock
  input wire logic clk,
  // Host port
  output logic [7:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus; released lines show the inverse of their last value
  initial begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // One byte write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask : wr

  // One byte read; data lands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1 d = io_rdata;
  endtask : rd

  // Setup word first, then both count bytes with nothing between them
  task automatic setup_and_count(input logic [7:0] cw_a, input logic [7:0] cw,
                                 input logic [7:0] cnt_a, input logic [15:0] cnt);
    wr(cw_a, cw);
    wr(cnt_a, cnt[7:0]);
    wr(cnt_a, cnt[15:8]);
  endtask : setup_and_count
endmodule : timer_host_model

// *** interval_timer_gate_and_programming_tb.sv ***
// Self-checking bench for the four-channel interval timer
module interval_timer_gate_and_programming_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tclk = 1'b0;
  logic [1:0] ext_gate = 2'h1;
  logic [4:0] tdiv = 5'h00;
  logic [7:0] io_addr, io_wdata, io_rdata, b0, b1;
  logic io_wr, io_rd;
  logic [3:0] timer_output_pin;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  // ---------------------------------------------------------------
  // Clocks and hang guard
  // ---------------------------------------------------------------
  always #10 clk = ~clk;
  // Timer clock of 20 system clocks, well under a quarter of clk
  always @(posedge clk) begin
    tdiv <= (tdiv == 5'h09) ? 5'h00 : tdiv + 5'h01;
    if (tdiv == 5'h09) tclk <= ~tclk;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  interval_timer_gate_and_programming i_interval_timer_gate_and_programming (.clk(clk),
    .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .shared_timer_clock_input(tclk), .ext_gate(ext_gate),
    .timer_output_pin(timer_output_pin));
  timer_host_model i_timer_host_model (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Timer clock falls until the output goes low after being high
  task automatic gap(input int idx, output int n);
    logic prev, hi;
    n = 0;
    hi = 1'b0;
    prev = tclk;
    repeat (2000) begin
      @(posedge clk);
      #1;
      if (prev && !tclk) n++;
      prev = tclk;
      if (timer_output_pin[idx] === 1'b1) hi = 1'b1;
      else if (hi) break;
    end
  endtask : gap

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reserved();
    logic [7:0] a [4] = '{8'h45, 8'h46, 8'h43, 8'h47};
    check({12'h000, timer_output_pin}, 16'h000f);
    i_timer_host_model.wr(8'h45, 8'h5a);
    i_timer_host_model.wr(8'h46, 8'ha5);
    foreach (a[i]) begin
      i_timer_host_model.rd(a[i], b0);
      check({8'h00, b0}, 16'h0000);
    end
    $display("test reserved done");
  endtask : t_reserved

  // Periodic modes on the two ungated timers
  task automatic t_periodic();
    i_timer_host_model.setup_and_count(8'h43, 8'h34, 8'h40, 16'h0003);
    gap(0, n);
    gap(0, n);
    check(16'(n), 16'h0003);
    i_timer_host_model.setup_and_count(8'h43, 8'h76, 8'h41, 16'h0004);
    gap(1, n);
    gap(1, n);
    check(16'(n), 16'h0004);
    $display("test periodic done");
  endtask : t_periodic

  // Decimal count of 10 runs through zero and wraps
  task automatic t_bcd_wrap();
    @(negedge tclk);
    i_timer_host_model.setup_and_count(8'h43, 8'h31, 8'h40, 16'h0010);
    repeat (16) @(negedge tclk);
    repeat (6) @(posedge clk);
    i_timer_host_model.wr(8'h43, 8'h00);
    i_timer_host_model.rd(8'h40, b0);
    i_timer_host_model.rd(8'h40, b1);
    check({b1, b0}, 16'h9995);
    $display("test bcd wrap done");
  endtask : t_bcd_wrap

  // Timer 2 rate mode held, triggered, then cut by the gate
  task automatic t_gate();
    ext_gate[0] <= 1'b0;
    i_timer_host_model.setup_and_count(8'h43, 8'hb4, 8'h42, 16'h0004);
    repeat (200) @(posedge clk);
    #1 check({15'h0000, timer_output_pin[2]}, 16'h0001);
    @(negedge tclk);
    @(posedge clk) ext_gate[0] <= 1'b1;
    gap(2, n);
    check(16'(n), 16'h0004);
    @(posedge clk) ext_gate[0] <= 1'b0;
    repeat (5) @(posedge clk);
    #1 check({15'h0000, timer_output_pin[2]}, 16'h0001);
    $display("test gate done");
  endtask : t_gate

  // Timer 3 strobe started by a gate edge
  task automatic t_strobe();
    i_timer_host_model.setup_and_count(8'h47, 8'h3a, 8'h44, 16'h0003);
    @(negedge tclk);
    @(posedge clk) ext_gate[1] <= 1'b1;
    gap(3, n);
    check(16'(n), 16'h0004);
    $display("test strobe done");
  endtask : t_strobe

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reserved();
    t_periodic();
    t_bcd_wrap();
    t_gate();
    t_strobe();
    results();
  end
endmodule : interval_timer_gate_and_programming_tb
